// *** rcm_pkg.sv ***
// Summary of operation
// - watchdog overflow raises an internal reset and sets the watchdog cause flag.
// - every internal reset source pulls the active-low reset pin low.
// - any write to address ffff clears the watchdog and prescaler stages 12..5.
// - prescaler ticks the watchdog at least once every 4080 clock cycles.
// - in monitor mode high test voltage on reset/interrupt pin disables watchdog.
// - in break state high test voltage on the reset pin disables the watchdog.
// - an illegal opcode sets the bad-opcode flag and resets the chip.
// - with stop enable clear, a stop instruction is an illegal opcode reset.
// - opcode fetch from unmapped space resets with bad-address flag; data fetch does not.
// - interrupts latch at processing start; latched one holds until serviced or unmasked.
// - reading the reset cause flags clears them all.
// - power-on sets only its flag clearing others; other sources add their own flag.
// - distinct flags for pin reset, blank-vector monitor entry and low voltage.
// - blank-vector monitor entry keeps the watchdog disabled whatever the pins.
// - monitor mode latches at reset pin rising edge; entry pins ignored afterwards.
// - after eight security bytes the device sends a break of ten zero bits.
// - monitor mode takes reset, break and software interrupt vectors from page fe.
// - removing high test voltage asserts watchdog enable, then gated by disable option.
// - high-voltage entry baud divisor 1024 if baud pin high else 512; blank ignores.
// - security mismatch keeps monitor mode, flash reads invalid, flash execution resets.
// - successful security sets bit 6 of the first internal ram byte.
package rcm_pkg;
	// prescaler and watchdog
	localparam int RCM_PRE_W = 12;
	localparam int RCM_PRE_CLR_LO = 4;
	localparam int RCM_PRE_CLR_HI = 11;
	localparam int RCM_TICK_PERIOD = 4080;
	localparam int RCM_WDOG_W = 8;
	localparam int RCM_RST_HOLD = 32;
	localparam logic [15:0] RCM_SERVICE_ADDR = 16'hffff;
	// vectors
	localparam logic [15:0] RCM_VEC_RST_USER = 16'hfffe;
	localparam logic [15:0] RCM_VEC_RST_MON = 16'hfefe;
	localparam logic [15:0] RCM_VEC_BRK_USER = 16'hfffc;
	localparam logic [15:0] RCM_VEC_BRK_MON = 16'hfefc;
	// monitor link
	localparam logic [15:0] RCM_SEC_FIRST = 16'hfff6;
	localparam logic [15:0] RCM_SEC_LAST = 16'hfffd;
	localparam int RCM_SEC_BYTES = 8;
	localparam int RCM_BREAK_BITS = 10;
	localparam int RCM_BAUD_W = 11;
	localparam logic [10:0] RCM_BAUD_HI = 11'h400;
	localparam logic [10:0] RCM_BAUD_LO = 11'h200;
	localparam logic [7:0] RCM_RAM_FLAG_ADDR = 8'h80;
	localparam int RCM_RAM_FLAG_BIT = 6;
	// register map
	localparam logic [3:0] RCM_OFS_CAUSE = 4'h0;
	localparam logic [3:0] RCM_OFS_CTRL = 4'h1;
	localparam logic [3:0] RCM_OFS_STAT = 4'h2;
	localparam int RCM_F_POR = 7;
	localparam int RCM_F_PIN = 6;
	localparam int RCM_F_WDOG = 5;
	localparam int RCM_F_OPC = 4;
	localparam int RCM_F_ADR = 3;
	localparam int RCM_F_MON = 2;
	localparam int RCM_F_LVI = 1;
	localparam logic [7:0] RCM_CAUSE_POR_VAL = 8'h80;
	localparam int RCM_C_STOP_EN = 0;
	localparam int RCM_C_WDOG_DIS = 1;
	localparam logic [7:0] RCM_CTRL_RST = 8'h00;
	typedef enum logic [3:0] {
		MS_IDLE = 4'b0001,
		MS_SEC = 4'b0010,
		MS_BRK = 4'b0100,
		MS_CMD = 4'b1000
	} rcm_mon_t;
	typedef enum logic [1:0] {
		VS_RESET = 2'h0,
		VS_BREAK = 2'h1,
		VS_SWI = 2'h2
	} rcm_vsel_t;
endpackage

// *** rcm_wdog.sv ***
`timescale 1ns/1ns
module rcm_wdog import rcm_pkg::*; #(
	parameter int PRE_W = RCM_PRE_W,
	parameter int WDOG_W = RCM_WDOG_W
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// control
	input wire logic run,
	input wire logic service,
	input wire logic clr,
	// result
	output logic overflow
);
	logic [PRE_W-1:0] pre_r;
	logic [WDOG_W-1:0] wd_r;
	logic tick;

	if (PRE_W < 12 || WDOG_W < 1) begin : g_chk
		$error("rcm_wdog: prescaler must hold twelve stages");
	end

	assign tick = (pre_r == PRE_W'(RCM_TICK_PERIOD - 1));

	always_ff @(posedge mclk) begin
		if (rst || clr) begin
			pre_r <= '0;
		end else if (service) begin
			pre_r[RCM_PRE_CLR_HI:RCM_PRE_CLR_LO] <= '0;
		end else if (tick) begin
			pre_r <= '0;
		end else begin
			pre_r <= pre_r + 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst || clr || service || !run) begin
			wd_r <= '0;
			overflow <= 1'b0;
		end else begin
			overflow <= tick && (&wd_r);
			if (tick) begin
				wd_r <= wd_r + 1'b1;
			end
		end
	end
endmodule

// *** rcm_top.sv ***
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ns
module rcm_top import rcm_pkg::*; #(
	parameter int N_INT = 4,
	parameter int RST_HOLD = RCM_RST_HOLD,
	parameter int WDOG_W = RCM_WDOG_W
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// core bus and decode
	input wire logic [15:0] cpu_addr,
	input wire logic cpu_wr,
	input wire logic cpu_opfetch,
	input wire logic addr_unmapped,
	input wire logic addr_in_flash,
	input wire logic illegal_op,
	input wire logic stop_op,
	input wire logic break_state,
	input wire logic lvi_reset,
	// vectors
	input wire logic vec_req,
	input wire logic [1:0] vec_sel,
	output logic [15:0] vec_addr,
	// interrupts
	input wire logic [N_INT-1:0] int_req,
	input wire logic i_mask,
	input wire logic int_start,
	input wire logic int_done,
	output logic int_latched,
	output logic [$clog2(N_INT)-1:0] int_id,
	// pins
	input wire logic rst_pin_n_in,
	output logic rst_pin_n_out,
	output logic rst_pin_n_oe,
	input wire logic hv_rst,
	input wire logic hv_irq,
	input wire logic baud_select_pin,
	input wire logic vector_blank,
	// monitor link
	input wire logic rx_valid,
	input wire logic [7:0] rx_byte,
	input wire logic [8*RCM_SEC_BYTES-1:0] sec_stored,
	output logic tx_line,
	// status outputs
	output logic chip_reset,
	output logic wdog_enable,
	output logic monitor_mode,
	output logic [RCM_BAUD_W-1:0] baud_div,
	output logic flash_read_invalid,
	output logic ram_flag_set
);
	localparam int IW = $clog2(N_INT);
	localparam int HW = $clog2(RST_HOLD + 1);

	if (N_INT < 2 || RST_HOLD < 1 || WDOG_W < 1) begin : g_chk
		$error("rcm_top: need two interrupts and a nonzero reset hold");
	end

	logic [7:0] cause_r;
	logic [7:0] cause_nxt;
	logic [7:0] ctrl_r;
	logic [HW-1:0] hold_r;
	logic pin_q_r;
	logic blank_r;
	logic sec_ok_r;
	logic sec_fail_r;
	logic match_r;
	logic i_mask_q_r;
	rcm_mon_t mon_r;
	logic [2:0] sec_cnt_r;
	logic [3:0] bit_cnt_r;
	logic [RCM_BAUD_W-1:0] baud_cnt_r;
	logic [IW-1:0] pick;
	logic pick_ok;
	logic pin_fall;
	logic pin_rise;
	logic driving;
	logic wd_hold;
	logic wd_run;
	logic wd_ovf;
	logic service;
	logic opc_evt;
	logic adr_evt;
	logic internal_evt;
	logic flash_locked;
	logic rd_clear;
	logic ent_hv;
	logic ent_blank;

	// pin edges seen by this block
	assign driving = rst_pin_n_oe;
	assign pin_fall = pin_q_r && !rst_pin_n_in;
	assign pin_rise = !pin_q_r && rst_pin_n_in;
	assign ent_hv = hv_irq;
	assign ent_blank = vector_blank && !hv_irq;

	// watchdog gating kept purely combinational on the test voltage
	// so the pins act without a latched copy; the blank-entry term uses stored monitor_mode and blank_r
	assign wd_hold = (monitor_mode && (hv_rst || hv_irq))
		|| (break_state && hv_rst)
		|| (monitor_mode && blank_r);
	assign wd_run = !wd_hold && !ctrl_r[RCM_C_WDOG_DIS];
	assign service = cpu_wr && (cpu_addr == RCM_SERVICE_ADDR);

	assign flash_locked = monitor_mode && !sec_ok_r;
	assign opc_evt = illegal_op || (stop_op && !ctrl_r[RCM_C_STOP_EN]);
	assign adr_evt = cpu_opfetch && (addr_unmapped || (addr_in_flash && flash_locked));
	assign internal_evt = wd_ovf || opc_evt || adr_evt || lvi_reset;
	assign rd_clear = reg_rd && (reg_addr == RCM_OFS_CAUSE);

	rcm_wdog #(
		.PRE_W(RCM_PRE_W),
		.WDOG_W(WDOG_W)
	) u_wdog (
		.mclk(mclk),
		.rst(rst),
		.run(wd_run),
		.service(service),
		.clr(chip_reset),
		.overflow(wd_ovf)
	);

	// cause flags: a new event in the reading cycle survives the clear
	always_comb begin
		cause_nxt = rd_clear ? 8'h00 : cause_r;
		cause_nxt[RCM_F_WDOG] = cause_nxt[RCM_F_WDOG] || wd_ovf;
		cause_nxt[RCM_F_OPC] = cause_nxt[RCM_F_OPC] || opc_evt;
		cause_nxt[RCM_F_ADR] = cause_nxt[RCM_F_ADR] || adr_evt;
		cause_nxt[RCM_F_LVI] = cause_nxt[RCM_F_LVI] || lvi_reset;
		cause_nxt[RCM_F_PIN] = cause_nxt[RCM_F_PIN] || (pin_fall && !driving);
		cause_nxt[RCM_F_MON] = cause_nxt[RCM_F_MON] || (pin_rise && ent_blank);
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cause_r <= RCM_CAUSE_POR_VAL;
		end else begin
			cause_r <= cause_nxt;
		end
	end

	// register reads, answered one cycle later
	always_ff @(posedge mclk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				RCM_OFS_CAUSE: reg_rdata <= cause_r;
				RCM_OFS_CTRL: reg_rdata <= ctrl_r;
				RCM_OFS_STAT: reg_rdata <= {monitor_mode, blank_r, sec_ok_r, sec_fail_r,
					wdog_enable, int_latched, chip_reset, tx_line};
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl_r <= RCM_CTRL_RST;
		end else if (reg_wr && reg_addr == RCM_OFS_CTRL) begin
			ctrl_r <= {6'h00, reg_wdata[RCM_C_WDOG_DIS], reg_wdata[RCM_C_STOP_EN]};
		end
	end

	// internal reset stretch and pin pull-down
	always_ff @(posedge mclk) begin
		if (rst) begin
			hold_r <= '0;
			chip_reset <= 1'b0;
			rst_pin_n_oe <= 1'b0;
			rst_pin_n_out <= 1'b0;
		end else begin
			rst_pin_n_out <= 1'b0;
			if (internal_evt) begin
				hold_r <= HW'(RST_HOLD);
				chip_reset <= 1'b1;
				rst_pin_n_oe <= 1'b1;
			end else if (hold_r != '0) begin
				hold_r <= hold_r - 1'b1;
				chip_reset <= (hold_r != HW'(1));
				rst_pin_n_oe <= (hold_r != HW'(1));
			end else begin
				chip_reset <= 1'b0;
				rst_pin_n_oe <= 1'b0;
			end
		end
	end

	// watchdog enable as seen outside
	always_ff @(posedge mclk) begin
		if (rst) begin
			wdog_enable <= 1'b0;
		end else begin
			wdog_enable <= !wd_hold;
		end
	end

	// monitor entry latch; entry pins only matter on the rising edge
	always_ff @(posedge mclk) begin
		if (rst) begin
			// idle level, so leaving reset is not a pin edge
			pin_q_r <= 1'b1;
			monitor_mode <= 1'b0;
			blank_r <= 1'b0;
			baud_div <= RCM_BAUD_HI;
		end else begin
			pin_q_r <= rst_pin_n_in;
			if (pin_rise) begin
				monitor_mode <= ent_hv || ent_blank;
				blank_r <= ent_blank;
				if (ent_hv && !baud_select_pin) begin
					baud_div <= RCM_BAUD_LO;
				end else begin
					baud_div <= RCM_BAUD_HI;
				end
			end
		end
	end

	// vector remap
	always_ff @(posedge mclk) begin
		if (rst) begin
			vec_addr <= RCM_VEC_RST_USER;
		end else if (vec_req) begin
			case (vec_sel)
				VS_BREAK, VS_SWI: vec_addr <= monitor_mode ? RCM_VEC_BRK_MON : RCM_VEC_BRK_USER;
				default: vec_addr <= monitor_mode ? RCM_VEC_RST_MON : RCM_VEC_RST_USER;
			endcase
		end
	end

	// interrupt arbitration: lowest index wins
	always_comb begin
		pick = '0;
		pick_ok = 1'b0;
		for (int i = N_INT - 1; i >= 0; i--) begin
			if (int_req[i]) begin
				pick = IW'(i);
				pick_ok = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst || chip_reset) begin
			i_mask_q_r <= 1'b1;
			int_latched <= 1'b0;
			int_id <= '0;
		end else begin
			i_mask_q_r <= i_mask;
			if (int_latched) begin
				// holds against any other request until released
				if (int_done || (i_mask_q_r && !i_mask)) begin
					int_latched <= 1'b0;
				end
			end else if (int_start && !i_mask && pick_ok) begin
				int_latched <= 1'b1;
				int_id <= pick;
			end
		end
	end

	// security exchange and ready break
	always_ff @(posedge mclk) begin
		if (rst) begin
			mon_r <= MS_IDLE;
			sec_cnt_r <= '0;
			bit_cnt_r <= '0;
			baud_cnt_r <= '0;
			match_r <= 1'b1;
			sec_ok_r <= 1'b0;
			sec_fail_r <= 1'b0;
			tx_line <= 1'b1;
			ram_flag_set <= 1'b0;
		end else begin
			ram_flag_set <= 1'b0;
			case (mon_r)
				MS_IDLE: begin
					tx_line <= 1'b1;
					if (pin_rise && (ent_hv || ent_blank)) begin
						mon_r <= MS_SEC;
						sec_cnt_r <= '0;
						match_r <= 1'b1;
					end
				end
				MS_SEC: begin
					if (rx_valid) begin
						sec_cnt_r <= sec_cnt_r + 1'b1;
						if (rx_byte != sec_stored[8*sec_cnt_r +: 8]) begin
							match_r <= 1'b0;
						end
						if (sec_cnt_r == 3'(RCM_SEC_BYTES - 1)) begin
							// a failure sticks until power-on, so a pin retry stays locked
							if (match_r && rx_byte == sec_stored[8*sec_cnt_r +: 8]
								&& !sec_fail_r) begin
								sec_ok_r <= 1'b1;
								ram_flag_set <= 1'b1;
							end else begin
								sec_ok_r <= 1'b0;
								sec_fail_r <= 1'b1;
							end
							mon_r <= MS_BRK;
							bit_cnt_r <= '0;
							baud_cnt_r <= '0;
							tx_line <= 1'b0;
						end
					end
				end
				MS_BRK: begin
					tx_line <= 1'b0;
					if (baud_cnt_r == baud_div - 1'b1) begin
						baud_cnt_r <= '0;
						if (bit_cnt_r == 4'(RCM_BREAK_BITS - 1)) begin
							mon_r <= MS_CMD;
							tx_line <= 1'b1;
						end else begin
							bit_cnt_r <= bit_cnt_r + 1'b1;
						end
					end else begin
						baud_cnt_r <= baud_cnt_r + 1'b1;
					end
				end
				MS_CMD: begin
					tx_line <= 1'b1;
					if (pin_rise && (ent_hv || ent_blank)) begin
						mon_r <= MS_SEC;
						sec_cnt_r <= '0;
						match_r <= 1'b1;
					end else if (pin_rise) begin
						mon_r <= MS_IDLE;
					end
				end
				default: mon_r <= MS_IDLE;
			endcase
		end
	end

	// flash reads are invalid while monitor security is not passed
	always_ff @(posedge mclk) begin
		if (rst) begin
			flash_read_invalid <= 1'b0;
		end else begin
			flash_read_invalid <= flash_locked;
		end
	end
endmodule

// *** rcm_top_asserts.sv ***
`timescale 1ns/1ns
module rcm_top_asserts import rcm_pkg::*; #(
	parameter int N_INT = 4,
	parameter int RST_HOLD = RCM_RST_HOLD
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// reset sources and pins
	input wire logic cpu_opfetch,
	input wire logic addr_unmapped,
	input wire logic illegal_op,
	input wire logic lvi_reset,
	input wire logic break_state,
	input wire logic hv_rst,
	input wire logic hv_irq,
	// vectors and interrupts
	input wire logic vec_req,
	input wire logic [1:0] vec_sel,
	input wire logic [15:0] vec_addr,
	input wire logic [N_INT-1:0] int_req,
	input wire logic i_mask,
	input wire logic int_start,
	input wire logic int_done,
	input wire logic int_latched,
	input wire logic [$clog2(N_INT)-1:0] int_id,
	// outputs
	input wire logic rst_pin_n_out,
	input wire logic rst_pin_n_oe,
	input wire logic tx_line,
	input wire logic chip_reset,
	input wire logic wdog_enable,
	input wire logic monitor_mode,
	input wire logic [RCM_BAUD_W-1:0] baud_div
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	chk_opc_reset: assert property (illegal_op |=> chip_reset && rst_pin_n_oe)
		else $error("illegal opcode gave no reset");
	chk_adr_reset: assert property (cpu_opfetch && addr_unmapped |=> chip_reset)
		else $error("unmapped opcode fetch gave no reset");
	chk_lvi_reset: assert property (lvi_reset |=> chip_reset && rst_pin_n_oe)
		else $error("low voltage event gave no reset");
	chk_pin_drive: assert property (chip_reset |-> rst_pin_n_oe && !rst_pin_n_out)
		else $error("reset pin not pulled low");
	chk_vec_page: assert property (vec_req |=> vec_addr ==
		{($past(monitor_mode) ? 8'hfe : 8'hff),
		(($past(vec_sel) == VS_BREAK || $past(vec_sel) == VS_SWI) ? 8'hfc : 8'hfe)})
		else $error("wrong vector address");
	chk_int_latch: assert property (int_start && !i_mask && |int_req && !int_latched
		&& !chip_reset |=> int_latched)
		else $error("interrupt not latched");
	// reset may clear the latch one cycle early, so it excuses the hold
	chk_int_hold: assert property (int_latched && !int_done && !chip_reset && !$fell(i_mask)
		|=> chip_reset || (int_latched && $stable(int_id)))
		else $error("latched interrupt displaced");
	chk_baud_vals: assert property (baud_div == RCM_BAUD_HI || baud_div == RCM_BAUD_LO)
		else $error("illegal baud divisor");
	chk_break_low: assert property ($fell(tx_line) |-> (!tx_line) [*8])
		else $error("break shorter than expected");
	chk_hv_wdog: assert property (monitor_mode && (hv_rst || hv_irq) |=> !wdog_enable)
		else $error("watchdog on under test voltage");
	chk_brk_wdog: assert property (break_state && hv_rst |=> !wdog_enable)
		else $error("watchdog on in break with test voltage");
	cover property (int_latched ##1 !int_latched);
	cover property ($fell(tx_line));
	cover property ($rose(chip_reset));
endmodule

bind rcm_top rcm_top_asserts #(.N_INT(N_INT), .RST_HOLD(RST_HOLD)) chk_u (
	.mclk(mclk), .rst(rst), .cpu_opfetch(cpu_opfetch), .addr_unmapped(addr_unmapped),
	.illegal_op(illegal_op), .lvi_reset(lvi_reset), .break_state(break_state),
	.hv_rst(hv_rst), .hv_irq(hv_irq), .vec_req(vec_req), .vec_sel(vec_sel),
	.vec_addr(vec_addr), .int_req(int_req), .i_mask(i_mask), .int_start(int_start),
	.int_done(int_done), .int_latched(int_latched), .int_id(int_id),
	.rst_pin_n_out(rst_pin_n_out), .rst_pin_n_oe(rst_pin_n_oe), .tx_line(tx_line),
	.chip_reset(chip_reset), .wdog_enable(wdog_enable), .monitor_mode(monitor_mode),
	.baud_div(baud_div)
);

// *** rcm_host.sv ***
`timescale 1ns/1ns
module rcm_host #(
	parameter logic [63:0] KEY = 64'h0
) (
	// clock
	input wire logic mclk,
	// control
	input wire logic go,
	output logic busy,
	// link to device
	output logic rx_valid,
	output logic [7:0] rx_byte
);
	int n = 0;
	int gap = 0;
	initial begin
		busy = 1'b0;
		rx_valid = 1'b0;
		rx_byte = 8'h00;
	end
	// idle data toggles so a stale byte can never look valid
	always @(posedge mclk) begin
		rx_valid <= 1'b0;
		rx_byte <= ~rx_byte;
		if (go && !busy) begin
			busy <= 1'b1;
			n <= 0;
			gap <= 0;
		end else if (busy) begin
			gap <= gap + 1;
			if (gap == 3) begin
				gap <= 0;
				rx_valid <= 1'b1;
				rx_byte <= KEY[8*n +: 8];
				n <= n + 1;
				if (n == 7) begin
					busy <= 1'b0;
				end
			end
		end
	end
endmodule

// *** rcm_top_tb.sv ***
`timescale 1ns/1ns
module rcm_top_tb;
	import rcm_pkg::*;
	localparam int HOLD = 4;
	localparam logic [63:0] KEY = 64'h5a4b3c2d1e0f1234;
	logic mclk = 0, rst = 1, reg_wr = 0, reg_rd = 0, cpu_wr = 0, cpu_opfetch = 0, stop_op = 0;
	logic addr_unmapped = 0, illegal_op = 0, break_state = 0, lvi_reset = 0, vec_req = 0;
	logic i_mask = 0, int_start = 0, int_done = 0, hv_rst = 0, hv_irq = 0, pin_ext = 1, go = 0;
	logic baud_select_pin = 1, vector_blank = 0;
	logic [1:0] vec_sel = 2'h0, int_id;
	logic [3:0] reg_addr = 4'h0, int_req = 4'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, rx_byte;
	logic [15:0] cpu_addr = 16'hffff, vec_addr;
	logic [10:0] baud_div;
	logic rx_valid, tx_line, chip_reset, wdog_enable, monitor_mode, flash_read_invalid;
	logic ram_flag_set, int_latched, rst_pin_n_out, rst_pin_n_oe, busy, rst_pin_n;
	int errors = 0, samples_checked = 0;
	// pulled up; the device only pulls it low
	assign rst_pin_n = rst_pin_n_oe ? rst_pin_n_out : pin_ext;
	// a one-bit watchdog keeps its overflow within reach of the run
	rcm_top #(.N_INT(4), .RST_HOLD(HOLD), .WDOG_W(1)) dut_u (
		.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
		.cpu_opfetch(cpu_opfetch), .addr_unmapped(addr_unmapped), .addr_in_flash(1'b0),
		.illegal_op(illegal_op), .stop_op(stop_op), .break_state(break_state),
		.lvi_reset(lvi_reset), .vec_req(vec_req), .vec_sel(vec_sel), .vec_addr(vec_addr),
		.int_req(int_req), .i_mask(i_mask), .int_start(int_start), .int_done(int_done),
		.int_latched(int_latched), .int_id(int_id), .rst_pin_n_in(rst_pin_n),
		.rst_pin_n_out(rst_pin_n_out), .rst_pin_n_oe(rst_pin_n_oe), .hv_rst(hv_rst),
		.hv_irq(hv_irq), .baud_select_pin(baud_select_pin), .vector_blank(vector_blank),
		.rx_valid(rx_valid), .rx_byte(rx_byte), .sec_stored(KEY), .tx_line(tx_line),
		.chip_reset(chip_reset), .wdog_enable(wdog_enable), .monitor_mode(monitor_mode),
		.baud_div(baud_div), .flash_read_invalid(flash_read_invalid),
		.ram_flag_set(ram_flag_set)
	);
	rcm_host #(.KEY(KEY)) host_u (
		.mclk(mclk), .go(go), .busy(busy), .rx_valid(rx_valid), .rx_byte(rx_byte)
	);
	initial forever #4 mclk = ~mclk;
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 check(reg_rdata, exp);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		#1;
	endtask
	// s: unmapped, opfetch, lvi, stop, illegal
	task automatic hit(input logic [4:0] s, input logic exp);
		{addr_unmapped, cpu_opfetch, lvi_reset, stop_op, illegal_op} <= s;
		@(posedge mclk);
		{addr_unmapped, cpu_opfetch, lvi_reset, stop_op, illegal_op} <= 5'h00;
		#1 check({chip_reset, rst_pin_n}, {exp, !exp});
		tick(HOLD + 2);
		#1 check(chip_reset, 1'b0);
	endtask
	task automatic vec(input logic [1:0] s, input logic [15:0] exp);
		vec_sel <= s;
		vec_req <= 1'b1;
		@(posedge mclk);
		vec_req <= 1'b0;
		#1 check(vec_addr, exp);
	endtask
	task automatic t_causes;
		rd(RCM_OFS_CAUSE, RCM_CAUSE_POR_VAL);
		rd(RCM_OFS_CAUSE, 8'h00);
		hit(5'h01, 1'b1);
		rd(RCM_OFS_CAUSE, 8'h10);
		wr(RCM_OFS_CTRL, 8'h01);
		hit(5'h02, 1'b0);
		wr(RCM_OFS_CTRL, 8'h00);
		hit(5'h02, 1'b1);
		hit(5'h10, 1'b0);
		hit(5'h18, 1'b1);
		hit(5'h04, 1'b1);
		rd(RCM_OFS_CAUSE, 8'h1a);
		rd(4'h9, 8'h00);
		$display("causes test done");
	endtask
	task automatic t_int;
		int_req <= 4'b0110;
		int_start <= 1'b1;
		@(posedge mclk);
		int_start <= 1'b0;
		#1 check({int_latched, int_id}, 3'b101);
		int_req <= 4'b0111;
		int_start <= 1'b1;
		@(posedge mclk);
		int_start <= 1'b0;
		#1 check({int_latched, int_id}, 3'b101);
		int_done <= 1'b1;
		@(posedge mclk);
		int_done <= 1'b0;
		#1 check(int_latched, 1'b0);
		int_start <= 1'b1;
		@(posedge mclk);
		int_start <= 1'b0;
		i_mask <= 1'b1;
		#1 check({int_latched, int_id}, 3'b100);
		@(posedge mclk);
		i_mask <= 1'b0;
		tick(2);
		#1 check(int_latched, 1'b0);
		int_req <= 4'h0;
		$display("interrupt test done");
	endtask
	task automatic t_wdog;
		vec(VS_RESET, RCM_VEC_RST_USER);
		vec(VS_BREAK, RCM_VEC_BRK_USER);
		vec(VS_SWI, RCM_VEC_BRK_USER);
		check(wdog_enable, 1'b1);
		break_state <= 1'b1;
		hv_rst <= 1'b1;
		tick(2);
		#1 check(wdog_enable, 1'b0);
		break_state <= 1'b0;
		hv_rst <= 1'b0;
		wr(RCM_OFS_CTRL, 8'h02);
		tick(2);
		rd(RCM_OFS_CTRL, 8'h02);
		check(wdog_enable, 1'b1);
		wr(RCM_OFS_CTRL, 8'h00);
		tick(2);
		#1 check(wdog_enable, 1'b1);
		$display("watchdog test done");
	endtask
	task automatic t_mon;
		int n;
		logic seen;
		hv_irq <= 1'b1;
		baud_select_pin <= 1'b0;
		pin_ext <= 1'b0;
		tick(3);
		pin_ext <= 1'b1;
		tick(3);
		baud_select_pin <= 1'b1;
		tick(2);
		#1 check({monitor_mode, wdog_enable}, 2'b10);
		check(baud_div, RCM_BAUD_LO);
		rd(RCM_OFS_CAUSE, 8'h40);
		vec(VS_RESET, RCM_VEC_RST_MON);
		vec(VS_SWI, RCM_VEC_BRK_MON);
		hv_irq <= 1'b0;
		tick(3);
		#1 check(wdog_enable, 1'b1);
		go <= 1'b1;
		@(posedge mclk);
		go <= 1'b0;
		n = 0;
		seen = 1'b0;
		while (tx_line !== 1'b0 && n < 200) begin
			@(posedge mclk);
			#1 n++;
			if (ram_flag_set === 1'b1) seen = 1'b1;
		end
		check(busy, 1'b0);
		n = 0;
		while (tx_line === 1'b0 && n < 6000) begin
			@(posedge mclk);
			#1 n++;
			if (ram_flag_set === 1'b1) seen = 1'b1;
		end
		check(16'(n), 16'(10 * RCM_BAUD_LO));
		check({seen, flash_read_invalid}, 2'b10);
		$display("monitor test done");
	endtask
	task automatic wait_rst(input int lim, output int n);
		n = 0;
		while (chip_reset !== 1'b1 && n < lim) begin
			@(posedge mclk);
			#1 n++;
		end
	endtask
	task automatic t_dog;
		int n;
		cpu_wr <= 1'b1;
		@(posedge mclk);
		cpu_wr <= 1'b0;
		wait_rst(6000, n);
		check(16'(n), 16'(6000));
		wr(RCM_OFS_CTRL, 8'h02);
		wait_rst(3000, n);
		check(16'(n), 16'(3000));
		wr(RCM_OFS_CTRL, 8'h00);
		wait_rst(9000, n);
		check(16'(n > RCM_TICK_PERIOD && n <= 2 * RCM_TICK_PERIOD + 2), 16'h0001);
		check(rst_pin_n, 1'b0);
		tick(HOLD + 2);
		rd(RCM_OFS_CAUSE, 8'h20);
		$display("watchdog overflow test done");
	endtask
	task automatic t_blank;
		vector_blank <= 1'b1;
		baud_select_pin <= 1'b0;
		pin_ext <= 1'b0;
		tick(3);
		pin_ext <= 1'b1;
		tick(3);
		#1 check({monitor_mode, wdog_enable}, 2'b10);
		check(baud_div, RCM_BAUD_HI);
		rd(RCM_OFS_CAUSE, 8'h44);
		$display("blank entry test done");
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		tick(2);
		rst <= 1'b0;
		tick(1);
		#1;
		t_causes;
		t_int;
		t_wdog;
		t_mon;
		t_dog;
		t_blank;
		test_done;
	end
	// the run needs about 21600 cycles, mostly the break and watchdog waits
	initial begin
		tick(50000);
		errors++;
		test_done;
	end
endmodule
